// ==== rtl/pwr_pkg.sv ====
package pwr_pkg;

    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 16;

    // register offsets
    localparam logic [7:0]  PEC_OFFSET        = 8'hD4;
    localparam logic [7:0]  WAKE_TIME_OFFSET  = 8'hD6;
    localparam logic [7:0]  INT_STATUS_OFFSET = 8'hDA;
    localparam logic [7:0]  INT_MASK_OFFSET   = 8'hDC;

    // power_event_control fields, then wake time register fields
    localparam int          PEC_DELAY_BIT     = 14;
    localparam int          PEC_POL_BIT       = 12;
    localparam int          PEC_EN_LSB        = 8;
    localparam int          PEC_AUTO_BIT      = 7;
    localparam int          PEC_NORM_BIT      = 6;
    localparam int          PEC_EVT_LSB       = 2;
    localparam int          PEC_MODE_LSB      = 0;
    localparam int          WAKE_UNITS_LSB    = 8;
    localparam int          SLEEP_UNITS_LSB   = 0;

    // wake cause codes
    localparam logic [3:0]  EVT_ENERGY        = 4'h1;
    localparam logic [3:0]  EVT_LINK          = 4'h2;
    localparam logic [3:0]  EVT_BCAST         = 4'h4;
    localparam logic [3:0]  EVT_FRAME         = 4'h8;

    // interrupt status bits
    localparam int          INT_ENERGY_BIT    = 2;
    localparam int          INT_LINK_BIT      = 3;
    localparam int          INT_NORMAL_BIT    = 4;
    localparam logic [15:0] INT_IMPL_MASK     = 16'h001C;

    // reset values
    localparam logic [7:0]  WAKE_UNITS_RESET  = 8'h08;
    localparam logic [7:0]  SLEEP_UNITS_RESET = 8'h0C;
    localparam logic        WAKE_OUT_RESET    = 1'b1;
    localparam logic        RX_TX_RESET       = 1'b1;

    // timing
    localparam int          WAKE_UNIT_MS      = 16;
    localparam int          CLK_PERIOD_NS     = 100;
    localparam int          WAKE_UNIT_CYCLES  = WAKE_UNIT_MS * 1000000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        PM_NORMAL    = 2'b00,
        PM_ENERGY    = 2'b01,
        PM_SOFT_DOWN = 2'b10,
        PM_SAVING    = 2'b11
    } pm_mode_e;

    typedef enum logic {
        ST_NORMAL_PWR = 1'b0,
        ST_LOW_PWR    = 1'b1
    } pwr_state_e;

endpackage : pwr_pkg

// ==== rtl/energy_persist.sv ====
`timescale 1ns/10ps
module energy_persist
    import pwr_pkg::*;
#(
    parameter int UNIT_CYCLES = WAKE_UNIT_CYCLES
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    // line energy and limit
    input  wire logic       energy,
    input  wire logic [7:0] wake_units,
    // result
    output logic            persisted
);

    localparam int               PRE_W    = $clog2(UNIT_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(UNIT_CYCLES - 1);

    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic [7:0]       units;
        logic             done;
    } persist_s;

    persist_s   st;
    persist_s   nx;
    logic [7:0] limit;

    always_comb begin
        nx    = st;
        limit = (wake_units == 8'h00) ? 8'h01 : wake_units;
        if (!energy) begin
            nx = '0;
        end else if (!st.done) begin
            if (st.pre == PRE_LAST) begin
                nx.pre   = '0;
                nx.units = st.units + 8'h01;
            end else begin
                nx.pre = st.pre + 1'b1;
            end
            nx.done = (nx.units >= limit);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else if (clk_en) begin
            st <= nx;
        end
    end

    assign persisted = st.done;

endmodule : energy_persist

// ==== rtl/wake_event_power_control.sv ====
`timescale 1ns/10ps
module wake_event_power_control
    import pwr_pkg::*;
#(
    parameter int WAKE_UNIT_CYCLES_P = WAKE_UNIT_CYCLES
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // line and mac events
    input  wire logic              energy_pin,
    input  wire logic              link_pin,
    input  wire logic              bcast_wake,
    input  wire logic              frame_wake,
    // power and wake outputs
    output logic                   wake_out,
    output logic      [1:0]        power_mode,
    output logic                   low_power,
    output logic                   rx_tx_en,
    output logic                   irq
);

    typedef struct packed {
        logic [2:0]        energy_sync;
        logic [2:0]        link_sync;
        logic              energy_lvl;
        logic              link_lvl;
        logic              persist_prev;
        logic              delay_en;
        logic              pol;
        logic [3:0]        wake_en;
        logic              auto_wake;
        logic              wake_norm;
        logic [3:0]        wake_evt;
        pm_mode_e          mode;
        pwr_state_e        pstate;
        logic [7:0]        wake_units;
        logic [7:0]        sleep_units;
        logic [15:0]       int_status;
        logic [15:0]       int_mask;
        logic [DATA_W-1:0] rdata;
        logic              wake_out;
        logic              rx_tx_en;
        logic              irq;
    } ctrl_s;

    ctrl_s       st;
    ctrl_s       nx;
    logic        persisted;
    logic        wr_pec;
    logic        wr_time;
    logic        wr_status;
    logic        wr_mask;
    logic        energy_wake;
    logic        link_rise;
    logic [3:0]  evt_set;
    logic [3:0]  evt_clr;
    logic [15:0] evt_next;
    logic [15:0] int_set;
    logic        hold;
    logic        wake_act;
    logic        wake_active;

    function automatic logic [15:0] w1c(input logic [15:0] cur,
                                        input logic [15:0] clr,
                                        input logic [15:0] set);
        return (cur & ~clr) | set;
    endfunction : w1c

    function automatic logic [15:0] pec_pack(input ctrl_s s);
        logic [15:0] r;
        r                       = '0;
        r[PEC_DELAY_BIT]        = s.delay_en;
        r[PEC_POL_BIT]          = s.pol;
        r[PEC_EN_LSB +: 4]      = s.wake_en;
        r[PEC_AUTO_BIT]         = s.auto_wake;
        r[PEC_NORM_BIT]         = s.wake_norm;
        r[PEC_EVT_LSB +: 4]     = s.wake_evt;
        r[PEC_MODE_LSB +: 2]    = s.mode;
        return r;
    endfunction : pec_pack

    energy_persist #(
        .UNIT_CYCLES (WAKE_UNIT_CYCLES_P)
    ) u_persist (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .energy     (st.energy_lvl),
        .wake_units (st.wake_units),
        .persisted  (persisted)
    );

    // address decode
    assign wr_pec    = reg_wr && (reg_addr == PEC_OFFSET);
    assign wr_time   = reg_wr && (reg_addr == WAKE_TIME_OFFSET);
    assign wr_status = reg_wr && (reg_addr == INT_STATUS_OFFSET);
    assign wr_mask   = reg_wr && (reg_addr == INT_MASK_OFFSET);

    // event detection
    assign energy_wake = persisted && !st.persist_prev
                         && (st.mode == PM_ENERGY) && (st.pstate == ST_LOW_PWR);
    assign link_rise   = (st.link_sync[1] == st.link_sync[2]) && st.link_sync[2]
                         && !st.link_lvl;
    assign evt_set     = (energy_wake ? EVT_ENERGY : 4'h0)
                       | (link_rise   ? EVT_LINK   : 4'h0)
                       | (bcast_wake  ? EVT_BCAST  : 4'h0)
                       | (frame_wake  ? EVT_FRAME  : 4'h0);
    assign evt_clr     = wr_pec ? reg_wdata[PEC_EVT_LSB +: 4] : 4'h0;
    assign evt_next    = w1c({12'h000, st.wake_evt}, {12'h000, evt_clr},
                             {12'h000, evt_set});

    always_comb begin
        nx       = st;
        int_set  = '0;
        hold     = 1'b0;
        wake_act = 1'b0;

        // line input synchronisers
        nx.energy_sync = {st.energy_sync[1:0], energy_pin};
        nx.link_sync   = {st.link_sync[1:0], link_pin};
        if (st.energy_sync[1] == st.energy_sync[2]) begin
            nx.energy_lvl = st.energy_sync[2];
        end
        if (st.link_sync[1] == st.link_sync[2]) begin
            nx.link_lvl = st.link_sync[2];
        end
        nx.persist_prev = persisted;

        // wake cause latch, set beats clear
        nx.wake_evt = evt_next[3:0];

        // host access ends low power
        if (reg_wr || reg_rd) begin
            nx.pstate = ST_NORMAL_PWR;
        end

        // automatic wake from low power
        if (energy_wake && st.auto_wake) begin
            nx.pstate               = ST_NORMAL_PWR;
            int_set[INT_NORMAL_BIT] = 1'b1;
            if (st.wake_norm) begin
                nx.mode = PM_NORMAL;
            end
        end
        int_set[INT_ENERGY_BIT] = energy_wake;
        int_set[INT_LINK_BIT]   = link_rise;

        // register writes
        if (wr_pec) begin
            nx.delay_en  = reg_wdata[PEC_DELAY_BIT];
            nx.pol       = reg_wdata[PEC_POL_BIT];
            nx.wake_en   = reg_wdata[PEC_EN_LSB +: 4];
            nx.auto_wake = reg_wdata[PEC_AUTO_BIT];
            nx.wake_norm = reg_wdata[PEC_NORM_BIT];
            nx.mode      = pm_mode_e'(reg_wdata[PEC_MODE_LSB +: 2]);
            if ((nx.mode == PM_ENERGY) && (st.mode != PM_ENERGY)) begin
                nx.pstate = ST_LOW_PWR;
            end
        end
        if (nx.mode != PM_ENERGY) begin
            nx.pstate = ST_NORMAL_PWR;
        end
        if (wr_time) begin
            nx.wake_units  = reg_wdata[WAKE_UNITS_LSB +: 8];
            nx.sleep_units = reg_wdata[SLEEP_UNITS_LSB +: 8];
        end
        if (wr_mask) begin
            nx.int_mask = reg_wdata & INT_IMPL_MASK;
        end
        nx.int_status = w1c(st.int_status, wr_status ? reg_wdata : 16'h0000, int_set)
                        & INT_IMPL_MASK;

        // wake indication pin
        hold        = nx.delay_en && nx.auto_wake && (nx.pstate == ST_LOW_PWR);
        wake_act    = (|(nx.wake_evt & nx.wake_en)) && !hold;
        nx.wake_out = nx.pol ? wake_act : !wake_act;

        // datapath enable per mode
        case (nx.mode)
            PM_NORMAL:    nx.rx_tx_en = 1'b1;
            PM_ENERGY:    nx.rx_tx_en = (nx.pstate == ST_NORMAL_PWR);
            PM_SOFT_DOWN: nx.rx_tx_en = 1'b0;
            PM_SAVING:    nx.rx_tx_en = 1'b1;
            default:      nx.rx_tx_en = 1'b0;
        endcase

        nx.irq = |(nx.int_status & nx.int_mask);

        // read data, valid one cycle
        nx.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                PEC_OFFSET:        nx.rdata = pec_pack(st);
                WAKE_TIME_OFFSET:  nx.rdata = {st.wake_units, st.sleep_units};
                INT_STATUS_OFFSET: nx.rdata = st.int_status;
                INT_MASK_OFFSET:   nx.rdata = st.int_mask;
                default:           nx.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st             <= '0;
            st.wake_units  <= WAKE_UNITS_RESET;
            st.sleep_units <= SLEEP_UNITS_RESET;
            st.wake_out    <= WAKE_OUT_RESET;
            st.rx_tx_en    <= RX_TX_RESET;
            st.mode        <= PM_NORMAL;
            st.pstate      <= ST_NORMAL_PWR;
        end else if (clk_en) begin
            st <= nx;
        end
    end

    assign reg_rdata  = st.rdata;
    assign wake_out   = st.wake_out;
    assign power_mode = st.mode;
    assign low_power  = (st.pstate == ST_LOW_PWR);
    assign rx_tx_en   = st.rx_tx_en;
    assign irq        = st.irq;

    // checks
    assign wake_active = (st.wake_out == st.pol);

    property p_energy_enable;
        @(posedge clk_sys) disable iff (!rst_n)
        energy_wake && st.wake_en[0] && !st.delay_en && clk_en && !reg_wr |=> wake_active;
    endproperty
    a_energy_enable: assert property (p_energy_enable)
        else $error("energy wake did not raise wake output");

    property p_link_enable;
        @(posedge clk_sys) disable iff (!rst_n)
        link_rise && st.wake_en[1] && !st.delay_en && clk_en && !reg_wr |=> wake_active;
    endproperty
    a_link_enable: assert property (p_link_enable)
        else $error("link wake did not raise wake output");

    property p_disabled_quiet;
        @(posedge clk_sys) disable iff (!rst_n)
        ((st.wake_evt & st.wake_en) == 4'h0) |-> !wake_active;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("wake output active without enabled cause");

    property p_packet_enable;
        @(posedge clk_sys) disable iff (!rst_n)
        ((bcast_wake && st.wake_en[2]) || (frame_wake && st.wake_en[3]))
        && !st.delay_en && clk_en && !reg_wr |=> wake_active;
    endproperty
    a_packet_enable: assert property (p_packet_enable)
        else $error("packet wake did not raise wake output");

    property p_soft_quiet;
        @(posedge clk_sys) disable iff (!rst_n)
        (st.mode == PM_SOFT_DOWN) |-> !st.rx_tx_en;
    endproperty
    a_soft_quiet: assert property (p_soft_quiet)
        else $error("datapath enabled in soft power down");

    property p_normal_traffic;
        @(posedge clk_sys) disable iff (!rst_n)
        (st.pstate == ST_NORMAL_PWR) && (st.mode != PM_SOFT_DOWN) |-> st.rx_tx_en;
    endproperty
    a_normal_traffic: assert property (p_normal_traffic)
        else $error("datapath off in normal power state");

    property p_auto_wake;
        @(posedge clk_sys) disable iff (!rst_n)
        energy_wake && st.auto_wake && clk_en && !reg_wr && !reg_rd
        |=> (st.pstate == ST_NORMAL_PWR) && st.int_status[INT_NORMAL_BIT];
    endproperty
    a_auto_wake: assert property (p_auto_wake)
        else $error("auto wake did not leave low power");

    property p_low_no_traffic;
        @(posedge clk_sys) disable iff (!rst_n)
        (st.pstate == ST_LOW_PWR) |-> !st.rx_tx_en;
    endproperty
    a_low_no_traffic: assert property (p_low_no_traffic)
        else $error("datapath enabled in low power state");

    property p_to_normal;
        @(posedge clk_sys) disable iff (!rst_n)
        energy_wake && st.auto_wake && st.wake_norm && clk_en && !reg_wr
        |=> (st.mode == PM_NORMAL) ##1 st.rx_tx_en;
    endproperty
    a_to_normal: assert property (p_to_normal)
        else $error("wake to normal mode failed");

    property p_stay_energy;
        @(posedge clk_sys) disable iff (!rst_n)
        energy_wake && !st.wake_norm && clk_en && !reg_wr |=> (st.mode == PM_ENERGY);
    endproperty
    a_stay_energy: assert property (p_stay_energy)
        else $error("mode left energy detect without request");

    property p_norm_ignored;
        @(posedge clk_sys) disable iff (!rst_n)
        energy_wake && !st.auto_wake && clk_en && !reg_wr && !reg_rd
        |=> (st.pstate == ST_LOW_PWR) && (st.mode == PM_ENERGY);
    endproperty
    a_norm_ignored: assert property (p_norm_ignored)
        else $error("wake acted with auto wake off");

    property p_w1c_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_pec && (reg_wdata[PEC_EVT_LSB +: 4] == 4'hF) && (evt_set == 4'h0) && clk_en
        |=> (st.wake_evt == 4'h0);
    endproperty
    a_w1c_clear: assert property (p_w1c_clear)
        else $error("wake cause not cleared by write one");

    property p_link_isr;
        @(posedge clk_sys) disable iff (!rst_n)
        link_rise && clk_en |=> st.int_status[INT_LINK_BIT] && st.wake_evt[1];
    endproperty
    a_link_isr: assert property (p_link_isr)
        else $error("link event not recorded");

    property p_restart;
        @(posedge clk_sys) disable iff (!rst_n)
        !st.energy_lvl && clk_en |=> !persisted;
    endproperty
    a_restart: assert property (p_restart)
        else $error("persistence not restarted on energy loss");

    c_auto_normal: cover property (@(posedge clk_sys) disable iff (!rst_n)
        energy_wake && st.auto_wake && st.wake_norm);
    c_link_wake:   cover property (@(posedge clk_sys) disable iff (!rst_n)
        link_rise && st.wake_en[1]);
    c_w1c:         cover property (@(posedge clk_sys) disable iff (!rst_n)
        wr_pec && (|(reg_wdata[PEC_EVT_LSB +: 4] & st.wake_evt)));
    c_delay_hold:  cover property (@(posedge clk_sys) disable iff (!rst_n)
        st.delay_en && st.auto_wake && (st.pstate == ST_LOW_PWR) && (|st.wake_evt));
    c_soft_down:   cover property (@(posedge clk_sys) disable iff (!rst_n)
        (st.mode == PM_SOFT_DOWN) && !st.rx_tx_en);

endmodule : wake_event_power_control

// ==== verif/line_model.sv ====
`timescale 1ns/10ps
module line_model (
    // clock
    input  wire logic clk_sys,
    // line and mac events
    output logic      energy_pin,
    output logic      link_pin,
    output logic      bcast_wake,
    output logic      frame_wake
);
    initial begin
        energy_pin = 1'b0;
        link_pin   = 1'b0;
        bcast_wake = 1'b0;
        frame_wake = 1'b0;
    end

    // line energy level, held until changed
    task automatic set_energy(input logic v);
        @(posedge clk_sys);
        energy_pin <= v;
    endtask : set_energy

    // one event: 0 broadcast, 1 frame, 2 link up
    task automatic fire(input int k);
        @(posedge clk_sys);
        case (k)
            0: bcast_wake <= 1'b1;
            1: frame_wake <= 1'b1;
            default: link_pin <= 1'b1;
        endcase
        @(posedge clk_sys);
        bcast_wake <= 1'b0;
        frame_wake <= 1'b0;
    endtask : fire
endmodule : line_model

// ==== verif/wake_event_power_control_tb_top.sv ====
`timescale 1ns/10ps
module wake_event_power_control_tb_top;
    import pwr_pkg::*;
    localparam int UNIT_P = 10;
    logic              clk_sys = 1'b0;
    logic              rst_n   = 1'b0;
    logic              clk_en  = 1'b1;
    logic [ADDR_W-1:0] reg_addr  = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic              energy_pin, link_pin, bcast_wake, frame_wake;
    logic              wake_out, low_power, rx_tx_en, irq;
    logic [1:0]        power_mode;
    int                n_mismatch = 0;
    int                checked    = 0;
    int                seed       = 52775;
    logic [15:0]       d;
    logic [15:0]       cfg;
    logic              pol, en, auto_w, norm_w;
    logic [15:0]       offs [5] = '{16'h00D4, 16'h00D6, 16'h00DA, 16'h00DC, 16'h0000};
    logic [15:0]       rstv [5] = '{16'h0000, 16'h080C, 16'h0000, 16'h0000, 16'h0000};
    int                enbit [3] = '{10, 11, 9};

    always #50 clk_sys = ~clk_sys;

    wake_event_power_control #(.WAKE_UNIT_CYCLES_P(UNIT_P)) u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .energy_pin(energy_pin), .link_pin(link_pin),
        .bcast_wake(bcast_wake), .frame_wake(frame_wake), .wake_out(wake_out),
        .power_mode(power_mode), .low_power(low_power), .rx_tx_en(rx_tx_en), .irq(irq));

    line_model u_line (
        .clk_sys(clk_sys), .energy_pin(energy_pin), .link_pin(link_pin),
        .bcast_wake(bcast_wake), .frame_wake(frame_wake));

    task automatic summarize();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk_reg

    task automatic chk_bit(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %b got %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_mode(input logic [1:0] e, input logic [1:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD power_mode exp %b got %b", e, g);
        end
    endtask : chk_mode

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(negedge clk_sys);
        v = reg_rdata;
    endtask : rd

    task automatic wait_wake();
        for (int i = 0; i < 100; i++) begin
            @(negedge clk_sys);
            if (low_power === 1'b0) begin
                return;
            end
        end
        n_mismatch++;
        $display("BAD wait_wake timed out");
        summarize();
    endtask : wait_wake

    function automatic logic exp_pin(input logic p, input logic on);
        return on ? p : ~p;
    endfunction : exp_pin

    function automatic logic [15:0] exp_code(input int k);
        case (k)
            0: return {12'h000, EVT_BCAST};
            1: return {12'h000, EVT_FRAME};
            default: return {12'h000, EVT_LINK};
        endcase
    endfunction : exp_code

    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        chk_bit("wake_out", 1'b1, wake_out);
        chk_mode(2'b00, power_mode);
        chk_bit("low_power", 1'b0, low_power);
        chk_bit("irq", 1'b0, irq);
        for (int i = 0; i < 5; i++) begin
            rd(offs[i][7:0], d);
            chk_reg("reset value", rstv[i], d);
        end
        wr(8'h00, 16'hFFFF);
        rd(8'h00, d);
        chk_reg("unmapped", 16'h0000, d);
        wr(8'hD4, 16'hA000);
        rd(8'hD4, d);
        chk_reg("reserved bits", 16'h0000, d);
        // each power mode in turn
        for (int m = 0; m < 4; m++) begin
            wr(8'hD4, 16'(m));
            @(negedge clk_sys);
            chk_mode(2'(m), power_mode);
            if (m == 1) begin
                chk_bit("low_power", 1'b1, low_power);
            end else begin
                chk_bit("rx_tx_en", m != 2, rx_tx_en);
            end
        end
        wr(8'hD4, 16'h0000);
        // clock enable low freezes register writes
        clk_en <= 1'b0;
        wr(8'hD4, 16'h0002);
        clk_en <= 1'b1;
        rd(8'hD4, d);
        chk_reg("frozen write", 16'h0000, d);
        // broadcast, frame, link events with random polarity; enable random for broadcast and frame, always set for link
        for (int k = 0; k < 3; k++) begin
            pol = 1'($random(seed));
            en  = (k == 2) ? 1'b1 : 1'($random(seed));
            cfg = (16'(pol) << PEC_POL_BIT) | (16'(en) << enbit[k]);
            wr(8'hD4, cfg);
            @(negedge clk_sys);
            chk_bit("wake_out idle", ~pol, wake_out);
            u_line.fire(k);
            repeat (8) @(posedge clk_sys);
            @(negedge clk_sys);
            chk_bit("wake_out event", exp_pin(pol, en), wake_out);
            rd(8'hD4, d);
            chk_reg("cause", exp_code(k), (d >> PEC_EVT_LSB) & 16'h000F);
            wr(8'hD4, cfg | (exp_code(k) << PEC_EVT_LSB));
            rd(8'hD4, d);
            chk_reg("cause cleared", 16'h0000, (d >> PEC_EVT_LSB) & 16'h000F);
            chk_bit("wake_out cleared", ~pol, wake_out);
        end
        // link up interrupt: masked, unmasked, cleared
        rd(8'hDA, d);
        chk_reg("int_status", 16'h0008, d);
        chk_bit("irq masked", 1'b0, irq);
        wr(8'hDC, 16'h0008);
        @(negedge clk_sys);
        chk_bit("irq", 1'b1, irq);
        wr(8'hDA, 16'h0008);
        @(negedge clk_sys);
        chk_bit("irq cleared", 1'b0, irq);
        wr(8'hDC, 16'h0014);
        // energy wake with three auto and normal settings
        wr(8'hD6, 16'h020C);
        rd(8'hD6, d);
        chk_reg("wake time", 16'h020C, d);
        for (int c = 0; c < 3; c++) begin
            auto_w = (c < 2);
            norm_w = (c != 1);
            u_line.set_energy(1'b0);
            wr(8'hD4, 16'h1101 | (16'(auto_w) << PEC_AUTO_BIT) | (16'(norm_w) << PEC_NORM_BIT));
            @(negedge clk_sys);
            chk_bit("low_power", 1'b1, low_power);
            chk_bit("wake_out idle", 1'b0, wake_out);
            u_line.set_energy(1'b1);
            if (c == 0) begin
                repeat (15) @(posedge clk_sys);
                u_line.set_energy(1'b0);
                repeat (2) @(posedge clk_sys);
                u_line.set_energy(1'b1);
                repeat (15) @(posedge clk_sys);
                @(negedge clk_sys);
                chk_bit("low_power restart", 1'b1, low_power);
            end
            if (auto_w) begin
                wait_wake();
            end else begin
                repeat (60) @(posedge clk_sys);
                @(negedge clk_sys);
            end
            chk_bit("low_power", ~auto_w, low_power);
            chk_mode((auto_w && norm_w) ? 2'b00 : 2'b01, power_mode);
            chk_bit("wake_out energy", 1'b1, wake_out);
            chk_bit("irq energy", 1'b1, irq);
            if (auto_w) begin
                chk_bit("rx_tx_en", 1'b1, rx_tx_en);
            end
            rd(8'hD4, d);
            chk_reg("cause energy", 16'h0001, (d >> PEC_EVT_LSB) & 16'h000F);
            rd(8'hDA, d);
            chk_reg("int_status", auto_w ? 16'h0014 : 16'h0004, d);
            wr(8'hD4, 16'h003C);
            wr(8'hDA, 16'h001C);
        end
        // delay enable holds the output while in low power
        wr(8'hD4, 16'h5481);
        u_line.fire(0);
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_bit("wake_out held", 1'b0, wake_out);
        rd(8'hD4, d);
        chk_bit("wake_out released", 1'b1, wake_out);
        chk_reg("cause bcast", 16'h0004, (d >> PEC_EVT_LSB) & 16'h000F);
        summarize();
    end
endmodule : wake_event_power_control_tb_top
